/* include/charger_regs_defs.svh */
// Register addresses, reset values and field positions for the charger
// control registers. Definitions only; included by the register bank.
`ifndef CHARGER_REGS_DEFS_SVH
`define CHARGER_REGS_DEFS_SVH

`define ADDR_CHARGE_CONTROL 8'h01
`define ADDR_FLOAT_VOLTAGE 8'h02
`define ADDR_CHIP_ID 8'h03
`define ADDR_CHIP_ID_ALT 8'h3b
`define ADDR_CHARGE_CURRENT 8'h04

`define RST_CHARGE_CONTROL 8'h30
`define RST_FLOAT_VOLTAGE 8'h0a
`define RST_CHARGE_CURRENT 8'h89

`define CC_INLIM_HI 7
`define CC_INLIM_LO 6
`define CC_WEAK_HI 5
`define CC_WEAK_LO 4
`define CC_TERM_BIT 3
`define CC_INHIBIT_BIT 2
`define CC_HIZ_BIT 1
`define CC_OPSEL_BIT 0

`define FV_CODE_HI 7
`define FV_CODE_LO 2
`define FV_POL_BIT 1
`define FV_GATE_BIT 0

`define IC_RESTORE_BIT 7
`define IC_MAXI_HI 6
`define IC_MAXI_LO 4
`define IC_RSVD_BIT 3
`define IC_TERM_HI 2
`define IC_TERM_LO 0

// Arbitrary neutral identity values
`define ID_SUPPLIER 3'h5
`define ID_VARIANT 2'h0
`define ID_REVISION 3'h0

`define ZERO_BYTE 8'h00

`endif

/* include/charger_regs_pkg.sv */
// Types shared by the charger register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package charger_regs_pkg;
	typedef enum logic [1:0] {
		MODE_CHARGE = 2'b00,
		MODE_BOOST = 2'b01,
		MODE_HIZ = 2'b10
	} op_mode_type;
endpackage : charger_regs_pkg

/* rtl/charger_control_registers.sv */
// Register bank for charge control, float voltage, identification and
// charge current. Assumes the serial bus engine (on clk) presents byte
// addresses and write strobes, MSB-first shifting done there.
`timescale 1ns/10ps
`include "charger_regs_defs.svh"

module charger_control_registers
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic [1:0] input_current_cap,
	output logic [1:0] weak_battery_threshold,
	output logic termination_gate,
	output logic charge_inhibit,
	output charger_regs_pkg::op_mode_type op_mode,
	output logic [5:0] float_voltage_code,
	output logic otg_pin_polarity,
	output logic otg_pin_gate,
	output logic [2:0] max_charge_current,
	output logic [2:0] termination_current_level
);
	import charger_regs_pkg::*;

	logic [7:0] charge_control_r;
	logic [7:0] float_voltage_r;
	logic [7:0] charge_current_r;
	logic restore;
	logic wr_cc;
	logic wr_fv;
	logic wr_ic;
	logic [7:0] rd_nxt;
	op_mode_type mode_nxt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	// High impedance wins over boost, so a stray boost bit cannot start
	// the converter while the input is meant to be isolated
	function automatic op_mode_type mode_decode(input logic [7:0] cc);
		if (cc[`CC_HIZ_BIT])
			mode_decode = MODE_HIZ;
		else if (cc[`CC_OPSEL_BIT])
			mode_decode = MODE_BOOST;
		else
			mode_decode = MODE_CHARGE;
	endfunction : mode_decode

	// Reset images, so field outputs start from the register defaults
	localparam logic [7:0] CC_DEFAULT = `RST_CHARGE_CONTROL;
	localparam logic [7:0] FV_DEFAULT = `RST_FLOAT_VOLTAGE;
	localparam logic [7:0] IC_DEFAULT = `RST_CHARGE_CURRENT;
	localparam op_mode_type MODE_DEFAULT = mode_decode(CC_DEFAULT);

	// Identification byte is fixed in silicon; writes to its
	// addresses are dropped
	localparam logic [7:0] ID_BYTE =
		{`ID_SUPPLIER, `ID_VARIANT, `ID_REVISION};

	// One write decode per register; a write reaches one register only, except a restore write, which reloads all three
	assign wr_cc = wr_en && hit(reg_addr, `ADDR_CHARGE_CONTROL);
	assign wr_fv = wr_en && hit(reg_addr, `ADDR_FLOAT_VOLTAGE);
	assign wr_ic = wr_en && hit(reg_addr, `ADDR_CHARGE_CURRENT);

	// Restore beats the field write in the same byte: the rest of that
	// byte is dropped, not stored on top of the defaults
	assign restore = wr_ic && wr_data[`IC_RESTORE_BIT];

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			charge_control_r <= `RST_CHARGE_CONTROL;
		else if (restore)
			charge_control_r <= `RST_CHARGE_CONTROL;
		else if (wr_cc)
			charge_control_r <= wr_data;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			float_voltage_r <= `RST_FLOAT_VOLTAGE;
		else if (restore)
			float_voltage_r <= `RST_FLOAT_VOLTAGE;
		else if (wr_fv)
			float_voltage_r <= wr_data;
	end

	// Restore bit and reserved bit are not stored; both read as 1
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			charge_current_r <= `RST_CHARGE_CURRENT;
		else if (restore)
			charge_current_r <= `RST_CHARGE_CURRENT;
		else if (wr_ic)
		begin
			charge_current_r[`IC_MAXI_HI:`IC_MAXI_LO] <=
				wr_data[`IC_MAXI_HI:`IC_MAXI_LO];
			charge_current_r[`IC_TERM_HI:`IC_TERM_LO] <=
				wr_data[`IC_TERM_HI:`IC_TERM_LO];
		end
	end

	always_comb
	begin
		if (hit(reg_addr, `ADDR_CHARGE_CONTROL))
			rd_nxt = charge_control_r;
		else if (hit(reg_addr, `ADDR_FLOAT_VOLTAGE))
			rd_nxt = float_voltage_r;
		else if (hit(reg_addr, `ADDR_CHIP_ID) ||
			hit(reg_addr, `ADDR_CHIP_ID_ALT))
			rd_nxt = ID_BYTE;
		else if (hit(reg_addr, `ADDR_CHARGE_CURRENT))
			rd_nxt = charge_current_r;
		else
			rd_nxt = `ZERO_BYTE;
	end

	// Read data held until the next read so the shifter can send it MSB first
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rd_data <= `ZERO_BYTE;
		else if (rd_en)
			rd_data <= rd_nxt;
	end

	// Mode decode is combinational inside the bank; only its registered
	// copy leaves, like every other field
	assign mode_nxt = mode_decode(charge_control_r);

	// Field outputs lag their register by one cycle, so the charger never
	// sees a byte that is still landing
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			input_current_cap <=
				CC_DEFAULT[`CC_INLIM_HI:`CC_INLIM_LO];
			weak_battery_threshold <=
				CC_DEFAULT[`CC_WEAK_HI:`CC_WEAK_LO];
			termination_gate <= CC_DEFAULT[`CC_TERM_BIT];
			charge_inhibit <= CC_DEFAULT[`CC_INHIBIT_BIT];
			op_mode <= MODE_DEFAULT;
		end
		else
		begin
			input_current_cap <=
				charge_control_r[`CC_INLIM_HI:`CC_INLIM_LO];
			weak_battery_threshold <=
				charge_control_r[`CC_WEAK_HI:`CC_WEAK_LO];
			termination_gate <= charge_control_r[`CC_TERM_BIT];
			charge_inhibit <= charge_control_r[`CC_INHIBIT_BIT];
			op_mode <= mode_nxt;
		end
	end

	// Float voltage code and OTG pin options
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			float_voltage_code <=
				FV_DEFAULT[`FV_CODE_HI:`FV_CODE_LO];
			otg_pin_polarity <= FV_DEFAULT[`FV_POL_BIT];
			otg_pin_gate <= FV_DEFAULT[`FV_GATE_BIT];
		end
		else
		begin
			float_voltage_code <=
				float_voltage_r[`FV_CODE_HI:`FV_CODE_LO];
			otg_pin_polarity <= float_voltage_r[`FV_POL_BIT];
			otg_pin_gate <= float_voltage_r[`FV_GATE_BIT];
		end
	end

	// Restore and reserved bits stay inside the bank; only the two
	// current codes reach the charge loop
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			max_charge_current <=
				IC_DEFAULT[`IC_MAXI_HI:`IC_MAXI_LO];
			termination_current_level <=
				IC_DEFAULT[`IC_TERM_HI:`IC_TERM_LO];
		end
		else
		begin
			max_charge_current <=
				charge_current_r[`IC_MAXI_HI:`IC_MAXI_LO];
			termination_current_level <=
				charge_current_r[`IC_TERM_HI:`IC_TERM_LO];
		end
	end

endmodule : charger_control_registers

/* sim/charger_properties.sv */
// Port checker for the charger register bank.
// Bound to charger_control_registers; one clock, low reset.
`timescale 1ns/10ps
module charger_properties
(
	input logic clk,
	input logic rstn,
	input logic [7:0] reg_addr,
	input logic [7:0] wr_data,
	input logic wr_en,
	input logic rd_en,
	input logic [7:0] rd_data,
	input logic [1:0] input_current_cap,
	input logic [1:0] weak_battery_threshold,
	input logic termination_gate,
	input logic charge_inhibit,
	input charger_regs_pkg::op_mode_type op_mode,
	input logic [5:0] float_voltage_code,
	input logic otg_pin_polarity,
	input logic otg_pin_gate,
	input logic [2:0] max_charge_current,
	input logic [2:0] termination_current_level
);
	wire logic [7:0] cc = {input_current_cap, weak_battery_threshold,
		termination_gate, charge_inhibit, op_mode};
	wire logic [7:0] fv = {float_voltage_code, otg_pin_polarity, otg_pin_gate};
	wire logic [5:0] ic = {max_charge_current, termination_current_level};
	wire logic w1 = wr_en && reg_addr == 8'h01;
	wire logic w4 = wr_en && reg_addr == 8'h04;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rstn);
	property p_rst;
		$rose(rstn) |-> cc == 8'h30 && fv == 8'h0a && ic == 6'h01;
	endproperty
	a_rst: assert property (p_rst) else $error("rst");
	property p_ctl;
		w1 |-> ##2 cc[7:2] == $past(wr_data[7:2], 2);
	endproperty
	a_ctl: assert property (p_ctl) else $error("ctl");
	property p_op;
		w1 |-> ##2 cc[1:0] == $past({wr_data[1], wr_data[0] & ~wr_data[1]}, 2);
	endproperty
	a_op: assert property (p_op) else $error("op");
	property p_fv;
		wr_en && reg_addr == 8'h02 |-> ##2 fv == $past(wr_data, 2);
	endproperty
	a_fv: assert property (p_fv) else $error("fv");
	property p_ic;
		w4 && !wr_data[7] |-> ##2 ic == $past({wr_data[6:4], wr_data[2:0]}, 2);
	endproperty
	a_ic: assert property (p_ic) else $error("ic");
	property p_rs;
		w4 && wr_data[7] |-> ##2 cc == 8'h30 && fv == 8'h0a && ic == 6'h01;
	endproperty
	a_rs: assert property (p_rs) else $error("rs");
	property p_id;
		rd_en && (reg_addr == 8'h03 || reg_addr == 8'h3b) |=> rd_data == 8'ha0;
	endproperty
	a_id: assert property (p_id) else $error("id");
	property p_rd4;
		rd_en && reg_addr == 8'h04 |=> rd_data[7] && rd_data[3];
	endproperty
	a_rd4: assert property (p_rd4) else $error("rd4");
endmodule : charger_properties
bind charger_control_registers charger_properties charger_properties_i (.*);

/* sim/host_model.sv */
// Serial host stand-in: one byte access per call on the register port.
// Assumes the bus engine has already deserialised the frame.
`timescale 1ns/10ps
module host_model
(
	input logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] wr_data,
	output logic wr_en,
	output logic rd_en
);
	initial {wr_en, rd_en, reg_addr, wr_data} = '0;
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(posedge clk);
		reg_addr <= a;
		wr_data <= d;
		wr_en <= w;
		rd_en <= !w;
		@(posedge clk);
		{wr_en, rd_en} <= 2'b00;
		// Released lines flip so a stale copy is never read
		reg_addr <= ~a;
		wr_data <= ~d;
		@(posedge clk);
	endtask : acc
endmodule : host_model

/* sim/testbench.sv */
// Bench for the charger register bank; host model drives the port.
// Checker is bound in; rd_data read once an access returns.
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr_en, rd_en, termination_gate, charge_inhibit, otg_pin_gate;
	logic otg_pin_polarity;
	logic [7:0] reg_addr, wr_data, rd_data;
	logic [1:0] input_current_cap, weak_battery_threshold;
	logic [5:0] float_voltage_code;
	logic [2:0] max_charge_current, termination_current_level;
	charger_regs_pkg::op_mode_type op_mode;
	int err_count, comparisons, cycles;
	logic [7:0] v [3] = '{8'hc6, 8'h39, 8'h03};
	charger_control_registers charger_control_registers_i (.*);
	host_model host_model_i (.*);
	task automatic chk(input logic [7:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %0t %h %h", $time, s, e);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, e);
		host_model_i.acc(1'b0, a, 8'h00);
		chk(rd_data, e);
	endtask : rc
	task automatic test_done;
		$display("errors %0d compares %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	initial forever #20 clk = ~clk;
	always @(posedge clk)
		if (++cycles == 1000)
		begin
			err_count++;
			test_done;
		end
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rc(8'h01, 8'h30);
		rc(8'h02, 8'h0a);
		rc(8'h04, 8'h89);
		chk({input_current_cap, weak_battery_threshold, termination_gate,
			charge_inhibit, op_mode}, 8'h30);
		chk({float_voltage_code, otg_pin_polarity, otg_pin_gate},
			8'h0a);
		chk({2'h0, max_charge_current, termination_current_level},
			8'h01);
		host_model_i.acc(1'b1, 8'h03, 8'h1f);
		rc(8'h03, 8'ha0);
		rc(8'h3b, 8'ha0);
		rc(8'h3c, 8'h00);
		foreach (v[i])
		begin
			host_model_i.acc(1'b1, 8'h01, v[i]);
			host_model_i.acc(1'b1, 8'h02, v[i]);
			rc(8'h01, v[i]);
			chk({input_current_cap, weak_battery_threshold, termination_gate,
				charge_inhibit, op_mode},
				{v[i][7:2], v[i][1], v[i][0] & ~v[i][1]});
			rc(8'h02, v[i]);
			chk({float_voltage_code, otg_pin_polarity, otg_pin_gate}, v[i]);
		end
		host_model_i.acc(1'b1, 8'h04, 8'h25);
		rc(8'h04, 8'had);
		chk({2'h0, max_charge_current, termination_current_level},
			8'h15);
		rc(8'h01, 8'h03);
		host_model_i.acc(1'b1, 8'h04, 8'h80);
		rc(8'h01, 8'h30);
		rc(8'h02, 8'h0a);
		rc(8'h04, 8'h89);
		chk({input_current_cap, weak_battery_threshold, termination_gate,
			charge_inhibit, op_mode}, 8'h30);
		chk({float_voltage_code, otg_pin_polarity, otg_pin_gate},
			8'h0a);
		chk({2'h0, max_charge_current, termination_current_level},
			8'h01);
		test_done;
	end
endmodule : testbench
